// File: pm_consts.vh
// Constants for the section and line performance monitoring counters
`ifndef PM_CONSTS_VH
`define PM_CONSTS_VH

// Counter and accumulator widths
`define CNT_W 32
`define ACC_W 24
`define B1_ERR_W 4
`define B2_ERR_W 11

// Number of STS paths monitored
`define NUM_PATHS 12

// Largest section parity error count in one frame
`define B1_MAX_ERR 4'h8

// Line rate factor and largest line parity error count per frame (8 x N)
`define STS_N 192
`define B2_MAX_ERR 11'h600

// Consecutive seconds needed to enter or leave the unavailable state
`define UNAVAIL_RUN 4'hA
`define RUN_W 4

// One-second tick timing
`define SEC_PERIOD_MS 1000
`define CLK_FREQ_KHZ 100000
`define SEC_CYCLES (`SEC_PERIOD_MS * `CLK_FREQ_KHZ)

// Reset values
`define CNT_RST 32'h0000_0000
`define ACC_RST 24'h00_0000
`define CNT_ONE 32'h0000_0001

`endif

// File: pm_event_counter.v
// Saturating event counter with a period clear
`timescale 1ns/100ps
`default_nettype none
`include "pm_consts.vh"

module pm_event_counter #(
  parameter WIDTH = `CNT_W
) (
  input wire clk_i,
  input wire srst_i,
  input wire clr_i,
  input wire inc_en_i,
  input wire [WIDTH-1:0] inc_i,
  output reg [WIDTH-1:0] count_o
);

  wire [WIDTH:0] sum;

  // Sum with carry to detect overflow
  assign sum = {1'b0, count_o} + {1'b0, inc_i};

  ////////////////////////////////////////////////////////////////////////
  // Count; an increment in the clear cycle survives the clear
  always @(posedge clk_i) begin
    if (srst_i) begin
      count_o <= {WIDTH{1'b0}};
    end else if (clr_i) begin
      count_o <= inc_en_i ? inc_i : {WIDTH{1'b0}};
    end else if (inc_en_i) begin
      count_o <= sum[WIDTH] ? {WIDTH{1'b1}} : sum[WIDTH-1:0]; // Saturate
    end
  end

endmodule
`default_nettype wire

// File: pm_path_justify.v
// Per-path pointer justification counters, detected and generated
`timescale 1ns/100ps
`default_nettype none
`include "pm_consts.vh"

module pm_path_justify (
  input wire clk_i,
  input wire srst_i,
  input wire clr_i,
  input wire [`NUM_PATHS-1:0] enable_i,
  input wire [`NUM_PATHS-1:0] pos_det_i,
  input wire [`NUM_PATHS-1:0] neg_det_i,
  input wire [`NUM_PATHS-1:0] pos_gen_i,
  input wire [`NUM_PATHS-1:0] neg_gen_i,
  output wire [`NUM_PATHS*`CNT_W-1:0] pos_det_cnt_o,
  output wire [`NUM_PATHS*`CNT_W-1:0] neg_det_cnt_o,
  output wire [`NUM_PATHS*`CNT_W-1:0] pos_gen_cnt_o,
  output wire [`NUM_PATHS*`CNT_W-1:0] neg_gen_cnt_o
);

  wire [4*`NUM_PATHS-1:0] events;
  wire [4*`NUM_PATHS*`CNT_W-1:0] counts;

  // Events gathered kind by kind, each gated by its path enable
  assign events = {neg_gen_i & enable_i, pos_gen_i & enable_i, neg_det_i & enable_i, pos_det_i & enable_i};

  ////////////////////////////////////////////////////////////////////////
  // One counter per path and kind
  genvar g;
  generate
    for (g = 0; g < 4*`NUM_PATHS; g = g + 1) begin : gen_cnt
      pm_event_counter #(
        .WIDTH(`CNT_W)
      ) u_cnt (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .clr_i(clr_i),
        .inc_en_i(events[g]),
        .inc_i(`CNT_ONE),
        .count_o(counts[g*`CNT_W +: `CNT_W])
      );
    end
  endgenerate

  // Split the counter bank into the four kinds
  assign pos_det_cnt_o = counts[0 +: `NUM_PATHS*`CNT_W];
  assign neg_det_cnt_o = counts[`NUM_PATHS*`CNT_W +: `NUM_PATHS*`CNT_W];
  assign pos_gen_cnt_o = counts[2*`NUM_PATHS*`CNT_W +: `NUM_PATHS*`CNT_W];
  assign neg_gen_cnt_o = counts[3*`NUM_PATHS*`CNT_W +: `NUM_PATHS*`CNT_W];

endmodule
`default_nettype wire

// File: pm_section_line.v
// Near-end section, line and path performance monitoring counters
//
// Operation
// - Count section parity errors, eight per frame
// - Each section error adds one to accumulator
// - Errored second on error, SEF or LOS
// - Severe second at threshold, SEF or LOS
// - Framing second counted on SEF only
// - Count line parity errors, 8xN per frame
// - Each line error adds one to accumulator
// - Line errored second on error or AIS
// - Line severe second at threshold or AIS
// - Ten severe seconds enter unavailable; count seconds
// - Ten clean seconds leave unavailable state
// - Failure event from line or lower failure
// - Spanning failure counted once, at its start
// - Count detected positive justifications per path
// - Count detected negative justifications per path
// - Count generated positive justifications per path
// - Count generated negative justifications per path
// - No path counts on ring protect channels
`timescale 1ns/100ps
`default_nettype none
`include "pm_consts.vh"

module pm_section_line #(
  parameter SEC_CYCLES = `SEC_CYCLES
) (
  input wire CLK_I,
  input wire SRST_I,
  input wire PERIOD_CLR_I,
  input wire FRAME_I,
  input wire [`B1_ERR_W-1:0] B1_ERR_I,
  input wire [`B2_ERR_W-1:0] B2_ERR_I,
  input wire SEF_I,
  input wire LOS_I,
  input wire AIS_L_I,
  input wire AIS_L_FAIL_I,
  input wire LOWER_FAIL_I,
  input wire [`ACC_W-1:0] SEC_SES_THRESH_I,
  input wire [`ACC_W-1:0] LINE_SES_THRESH_I,
  input wire BLSR_MODE_I,
  input wire [`NUM_PATHS-1:0] PATH_PROTECT_I,
  input wire [`NUM_PATHS-1:0] PJ_POS_DET_I,
  input wire [`NUM_PATHS-1:0] PJ_NEG_DET_I,
  input wire [`NUM_PATHS-1:0] PJ_POS_GEN_I,
  input wire [`NUM_PATHS-1:0] PJ_NEG_GEN_I,
  output reg SECOND_TICK_O,
  output reg [`ACC_W-1:0] CUR_SEC_B1_O,
  output reg [`ACC_W-1:0] CUR_SEC_B2_O,
  output wire [`CNT_W-1:0] SECTION_CODE_VIOLATION_COUNT_O,
  output wire [`CNT_W-1:0] SECTION_ERRORED_SECONDS_O,
  output wire [`CNT_W-1:0] SECTION_SEVERE_ERRORED_SECONDS_O,
  output wire [`CNT_W-1:0] SECTION_FRAMING_ERROR_SECONDS_O,
  output wire [`CNT_W-1:0] LINE_CODE_VIOLATION_COUNT_O,
  output wire [`CNT_W-1:0] LINE_ERRORED_SECONDS_O,
  output wire [`CNT_W-1:0] LINE_SEVERE_ERRORED_SECONDS_O,
  output wire [`CNT_W-1:0] LINE_UNAVAILABLE_SECONDS_O,
  output wire [`CNT_W-1:0] LINE_FAILURE_EVENT_COUNT_O,
  output reg LINE_UNAVAILABLE_O,
  output reg LINE_FAILURE_ACTIVE_O,
  output wire [`NUM_PATHS*`CNT_W-1:0] PATH_POS_JUSTIFY_DETECTED_O,
  output wire [`NUM_PATHS*`CNT_W-1:0] PATH_NEG_JUSTIFY_DETECTED_O,
  output wire [`NUM_PATHS*`CNT_W-1:0] PATH_POS_JUSTIFY_GENERATED_O,
  output wire [`NUM_PATHS*`CNT_W-1:0] PATH_NEG_JUSTIFY_GENERATED_O
);

  // Availability states
  localparam ST_AVAIL = 1'b0;
  localparam ST_UNAVAIL = 1'b1;

  // Last cycle of the one-second divider
  localparam [31:0] DIV_LAST = SEC_CYCLES - 1;

  reg [31:0] div_ff;
  reg tick_ff;
  reg sef_seen_ff;
  reg los_seen_ff;
  reg ais_seen_ff;
  reg fail_prev_ff;
  reg state_ff;
  reg nxt_state;
  reg [`RUN_W-1:0] run_ff;
  reg [`RUN_W-1:0] nxt_run;
  reg [`ACC_W-1:0] nxt_b1_acc;
  reg [`ACC_W-1:0] nxt_b2_acc;

  wire [`B1_ERR_W-1:0] b1_clip;
  wire [`B2_ERR_W-1:0] b2_clip;
  wire [`ACC_W:0] b1_sum;
  wire [`ACC_W:0] b2_sum;
  wire [`ACC_W-1:0] b1_now;
  wire [`ACC_W-1:0] b2_now;
  wire sef_any;
  wire los_any;
  wire ais_any;
  wire sec_def;
  wire sec_es;
  wire sec_ses;
  wire line_es;
  wire line_ses;
  wire fail_now;
  wire fail_start;
  wire uas_inc;
  wire [`NUM_PATHS-1:0] path_en;

  // Saturate an accumulator sum
  function [`ACC_W-1:0] sat_acc;
    input [`ACC_W:0] s;
    begin
      sat_acc = s[`ACC_W] ? {`ACC_W{1'b1}} : s[`ACC_W-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // One-second divider; tick is a one-cycle enable, mirrored to the port
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      div_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
      SECOND_TICK_O <= 1'b0;
    end else if (div_ff == DIV_LAST) begin
      div_ff <= 32'h0000_0000;
      tick_ff <= 1'b1;
      SECOND_TICK_O <= 1'b1;
    end else begin
      div_ff <= div_ff + 32'h0000_0001;
      tick_ff <= 1'b0;
      SECOND_TICK_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-frame error counts, limited to what one frame can carry
  assign b1_clip = (B1_ERR_I > `B1_MAX_ERR) ? `B1_MAX_ERR : B1_ERR_I;
  assign b2_clip = (B2_ERR_I > `B2_MAX_ERR) ? `B2_MAX_ERR : B2_ERR_I;

  // Accumulator value including this cycle's frame
  assign b1_sum = {1'b0, CUR_SEC_B1_O} + {{(`ACC_W+1-`B1_ERR_W){1'b0}}, (FRAME_I ? b1_clip : 4'h0)};
  assign b2_sum = {1'b0, CUR_SEC_B2_O} + {{(`ACC_W+1-`B2_ERR_W){1'b0}}, (FRAME_I ? b2_clip : 11'h000)};
  assign b1_now = sat_acc(b1_sum);
  assign b2_now = sat_acc(b2_sum);

  // Accumulators restart at each tick, no error lost in the tick cycle
  always @* begin
    nxt_b1_acc = b1_now;
    nxt_b2_acc = b2_now;
    if (tick_ff) begin
      nxt_b1_acc = `ACC_RST;
      nxt_b2_acc = `ACC_RST;
    end
  end

  // Current-second accumulators
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      CUR_SEC_B1_O <= `ACC_RST;
      CUR_SEC_B2_O <= `ACC_RST;
    end else begin
      CUR_SEC_B1_O <= nxt_b1_acc;
      CUR_SEC_B2_O <= nxt_b2_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Defects seen at any time within the current second
  always @(posedge CLK_I) begin
    if (SRST_I || tick_ff) begin
      sef_seen_ff <= 1'b0;
      los_seen_ff <= 1'b0;
      ais_seen_ff <= 1'b0;
    end else begin
      sef_seen_ff <= sef_seen_ff | SEF_I;
      los_seen_ff <= los_seen_ff | LOS_I;
      ais_seen_ff <= ais_seen_ff | AIS_L_I;
    end
  end

  // Defect presence including the tick cycle itself
  assign sef_any = sef_seen_ff | SEF_I;
  assign los_any = los_seen_ff | LOS_I;
  assign ais_any = ais_seen_ff | AIS_L_I;

  ////////////////////////////////////////////////////////////////////////
  // Per-second qualification
  assign sec_def = sef_any | los_any;
  assign sec_es = (b1_now != `ACC_RST) | sec_def;
  assign sec_ses = (b1_now >= SEC_SES_THRESH_I) | sec_def;
  assign line_es = (b2_now != `ACC_RST) | ais_any;
  assign line_ses = (b2_now >= LINE_SES_THRESH_I) | ais_any;

  ////////////////////////////////////////////////////////////////////////
  // Availability state and run of qualifying seconds
  always @* begin
    nxt_state = state_ff;
    nxt_run = run_ff;
    if (tick_ff) begin
      case (state_ff)
        ST_AVAIL: begin
          if (!line_ses) begin
            nxt_run = {`RUN_W{1'b0}};
          end else if (run_ff == `UNAVAIL_RUN - 4'h1) begin
            nxt_state = ST_UNAVAIL;
            nxt_run = {`RUN_W{1'b0}};
          end else begin
            nxt_run = run_ff + 4'h1;
          end
        end
        ST_UNAVAIL: begin
          if (line_ses) begin
            nxt_run = {`RUN_W{1'b0}};
          end else if (run_ff == `UNAVAIL_RUN - 4'h1) begin
            nxt_state = ST_AVAIL;
            nxt_run = {`RUN_W{1'b0}};
          end else begin
            nxt_run = run_ff + 4'h1;
          end
        end
        default: begin
          nxt_state = ST_AVAIL;
          nxt_run = {`RUN_W{1'b0}};
        end
      endcase
    end
  end

  // State registers
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      state_ff <= ST_AVAIL;
      run_ff <= {`RUN_W{1'b0}};
      LINE_UNAVAILABLE_O <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      run_ff <= nxt_run;
      LINE_UNAVAILABLE_O <= nxt_state == ST_UNAVAIL;
    end
  end

  // Second counted when it ends in the unavailable state
  assign uas_inc = tick_ff & (nxt_state == ST_UNAVAIL);

  ////////////////////////////////////////////////////////////////////////
  // Failure event starts on the rising edge of the OR of both failures
  assign fail_now = AIS_L_FAIL_I | LOWER_FAIL_I;
  assign fail_start = fail_now & ~fail_prev_ff;

  // Failure history
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      fail_prev_ff <= 1'b0;
      LINE_FAILURE_ACTIVE_O <= 1'b0;
    end else begin
      fail_prev_ff <= fail_now;
      LINE_FAILURE_ACTIVE_O <= fail_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Section counters
  pm_event_counter #(.WIDTH(`CNT_W)) u_sec_cv (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .inc_en_i(tick_ff),
    .inc_i({{(`CNT_W-`ACC_W){1'b0}}, b1_now}),
    .count_o(SECTION_CODE_VIOLATION_COUNT_O)
  );

  pm_event_counter #(.WIDTH(`CNT_W)) u_sec_es (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .inc_en_i(tick_ff & sec_es),
    .inc_i(`CNT_ONE),
    .count_o(SECTION_ERRORED_SECONDS_O)
  );

  pm_event_counter #(.WIDTH(`CNT_W)) u_sec_ses (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .inc_en_i(tick_ff & sec_ses),
    .inc_i(`CNT_ONE),
    .count_o(SECTION_SEVERE_ERRORED_SECONDS_O)
  );

  pm_event_counter #(.WIDTH(`CNT_W)) u_sec_sefs (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .inc_en_i(tick_ff & sef_any),
    .inc_i(`CNT_ONE),
    .count_o(SECTION_FRAMING_ERROR_SECONDS_O)
  );

  ////////////////////////////////////////////////////////////////////////
  // Line counters
  pm_event_counter #(.WIDTH(`CNT_W)) u_line_cv (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .inc_en_i(tick_ff),
    .inc_i({{(`CNT_W-`ACC_W){1'b0}}, b2_now}),
    .count_o(LINE_CODE_VIOLATION_COUNT_O)
  );

  pm_event_counter #(.WIDTH(`CNT_W)) u_line_es (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .inc_en_i(tick_ff & line_es),
    .inc_i(`CNT_ONE),
    .count_o(LINE_ERRORED_SECONDS_O)
  );

  pm_event_counter #(.WIDTH(`CNT_W)) u_line_ses (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .inc_en_i(tick_ff & line_ses),
    .inc_i(`CNT_ONE),
    .count_o(LINE_SEVERE_ERRORED_SECONDS_O)
  );

  pm_event_counter #(.WIDTH(`CNT_W)) u_line_uas (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .inc_en_i(uas_inc),
    .inc_i(`CNT_ONE),
    .count_o(LINE_UNAVAILABLE_SECONDS_O)
  );

  // Period clear never recounts an event already in progress
  pm_event_counter #(.WIDTH(`CNT_W)) u_line_fc (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .inc_en_i(fail_start),
    .inc_i(`CNT_ONE),
    .count_o(LINE_FAILURE_EVENT_COUNT_O)
  );

  ////////////////////////////////////////////////////////////////////////
  // Path justification counters, suppressed on ring protect channels
  assign path_en = ~({`NUM_PATHS{BLSR_MODE_I}} & PATH_PROTECT_I);

  pm_path_justify u_path (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .clr_i(PERIOD_CLR_I),
    .enable_i(path_en),
    .pos_det_i(PJ_POS_DET_I),
    .neg_det_i(PJ_NEG_DET_I),
    .pos_gen_i(PJ_POS_GEN_I),
    .neg_gen_i(PJ_NEG_GEN_I),
    .pos_det_cnt_o(PATH_POS_JUSTIFY_DETECTED_O),
    .neg_det_cnt_o(PATH_NEG_JUSTIFY_DETECTED_O),
    .pos_gen_cnt_o(PATH_POS_JUSTIFY_GENERATED_O),
    .neg_gen_cnt_o(PATH_NEG_JUSTIFY_GENERATED_O)
  );

endmodule
`default_nettype wire

// File: pm_framer_model.sv
// Framer model that hands frames with parity error counts to the counters
`timescale 1ns/100ps
`default_nettype none
`include "pm_consts.vh"
module pm_framer_model (
  input wire logic clk_i,
  output logic frame_o,
  output logic [`B1_ERR_W-1:0] b1_o,
  output logic [`B2_ERR_W-1:0] b2_o
);
  // Idle: no frame, counts meaningless
  initial begin
    frame_o = 1'b0;
    b1_o = 4'hF;
    b2_o = 11'h7FF;
  end
  // One frame per call; strobe held through a burst, counts flip once it drops
  task send(input [`B1_ERR_W-1:0] b1, input [`B2_ERR_W-1:0] b2, input last);
    begin
      frame_o <= 1'b1;
      b1_o <= b1;
      b2_o <= b2;
      @(posedge clk_i);
      if (last) begin
        frame_o <= 1'b0;
        b1_o <= ~b1;
        b2_o <= ~b2;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: pm_section_line_asserts.sv
// Concurrent checks on the counter block ports
`timescale 1ns/100ps
`default_nettype none
`include "pm_consts.vh"
module pm_section_line_asserts #(
  parameter SEC_CYCLES = 50
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic PERIOD_CLR_I,
  input wire logic FRAME_I,
  input wire logic [`B1_ERR_W-1:0] B1_ERR_I,
  input wire logic SEF_I,
  input wire logic LOS_I,
  input wire logic AIS_L_I,
  input wire logic AIS_L_FAIL_I,
  input wire logic LOWER_FAIL_I,
  input wire logic BLSR_MODE_I,
  input wire logic [`NUM_PATHS-1:0] PATH_PROTECT_I,
  input wire logic SECOND_TICK_O,
  input wire logic [`ACC_W-1:0] CUR_SEC_B1_O,
  input wire logic [`CNT_W-1:0] SECTION_CODE_VIOLATION_COUNT_O,
  input wire logic [`CNT_W-1:0] SECTION_ERRORED_SECONDS_O,
  input wire logic [`CNT_W-1:0] SECTION_SEVERE_ERRORED_SECONDS_O,
  input wire logic [`CNT_W-1:0] SECTION_FRAMING_ERROR_SECONDS_O,
  input wire logic [`CNT_W-1:0] LINE_ERRORED_SECONDS_O,
  input wire logic [`CNT_W-1:0] LINE_SEVERE_ERRORED_SECONDS_O,
  input wire logic [`CNT_W-1:0] LINE_FAILURE_EVENT_COUNT_O,
  input wire logic LINE_UNAVAILABLE_O,
  input wire logic [`NUM_PATHS*`CNT_W-1:0] PATH_POS_JUSTIFY_DETECTED_O
);
  reg [31:0] gap_ff;
  wire [31:0] nxt_gap = SECOND_TICK_O ? 32'h1 : gap_ff + 32'h1;
  // Cycles since reset or since the last tick
  always @(posedge CLK_I) begin
    if (SRST_I) gap_ff <= 32'h0;
    else gap_ff <= nxt_gap;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  ////////////////////////////////////////////////////////////
  tick_spacing_a: assert property (SECOND_TICK_O == (gap_ff == SEC_CYCLES))
    else $error("second tick off period");
  b1_accumulate_a: assert property (FRAME_I && !SECOND_TICK_O |=>
    CUR_SEC_B1_O == $past(CUR_SEC_B1_O) + ($past(B1_ERR_I) > 4'h8 ? 4'h8 : $past(B1_ERR_I)))
    else $error("section accumulator wrong");
  cv_second_a: assert property (SECOND_TICK_O && !FRAME_I && !PERIOD_CLR_I |=>
    SECTION_CODE_VIOLATION_COUNT_O == $past(SECTION_CODE_VIOLATION_COUNT_O) + $past(CUR_SEC_B1_O))
    else $error("section violations not added");
  acc_clear_a: assert property (SECOND_TICK_O |=> CUR_SEC_B1_O == 24'h0)
    else $error("accumulator not cleared");
  sec_defect_a: assert property (SECOND_TICK_O && (SEF_I || LOS_I) && !PERIOD_CLR_I |=>
    SECTION_ERRORED_SECONDS_O == $past(SECTION_ERRORED_SECONDS_O) + 32'h1 &&
    SECTION_SEVERE_ERRORED_SECONDS_O == $past(SECTION_SEVERE_ERRORED_SECONDS_O) + 32'h1)
    else $error("section defect second missed");
  framing_sec_a: assert property (SECOND_TICK_O && SEF_I && !PERIOD_CLR_I |=>
    SECTION_FRAMING_ERROR_SECONDS_O == $past(SECTION_FRAMING_ERROR_SECONDS_O) + 32'h1)
    else $error("framing second missed");
  line_defect_a: assert property (SECOND_TICK_O && AIS_L_I && !PERIOD_CLR_I |=>
    LINE_ERRORED_SECONDS_O == $past(LINE_ERRORED_SECONDS_O) + 32'h1 &&
    LINE_SEVERE_ERRORED_SECONDS_O == $past(LINE_SEVERE_ERRORED_SECONDS_O) + 32'h1)
    else $error("line defect second missed");
  unavail_edge_a: assert property ($changed(LINE_UNAVAILABLE_O) && !$past(SRST_I) |->
    $past(SECOND_TICK_O))
    else $error("unavailable state moved off tick");
  fail_count_a: assert property ($rose(AIS_L_FAIL_I || LOWER_FAIL_I) && !PERIOD_CLR_I |=>
    LINE_FAILURE_EVENT_COUNT_O == $past(LINE_FAILURE_EVENT_COUNT_O) + 32'h1)
    else $error("failure event not counted");
  protect_path_a: assert property (BLSR_MODE_I && PATH_PROTECT_I[4] && !PERIOD_CLR_I |=>
    $stable(PATH_POS_JUSTIFY_DETECTED_O[159:128]))
    else $error("protect path counted");
endmodule
bind pm_section_line pm_section_line_asserts #(.SEC_CYCLES(SEC_CYCLES)) i_pm_section_line_asserts (.*);
`default_nettype wire

// File: pm_section_line_bench.sv
// Self-checking bench for the section and line counters
`timescale 1ns/100ps
`default_nettype none
`include "pm_consts.vh"
module pm_section_line_bench;
  reg clk, srst, pclr, sef, los, ais, aisf, lowf, blsr;
  reg [`ACC_W-1:0] sk, lk;
  reg [`NUM_PATHS-1:0] prot, pd, nd, pg, ng;
  wire frame, tick, unav, fact;
  wire [`B1_ERR_W-1:0] b1;
  wire [`B2_ERR_W-1:0] b2;
  wire [`ACC_W-1:0] acc1, acc2;
  wire [`CNT_W-1:0] cvs, ess, sess, sefs, cvl, esl, sesl, uas, fc;
  wire [`NUM_PATHS*`CNT_W-1:0] ppd, pnd, ppg, png;
  integer bad_count = 0;
  integer total_checks = 0;
  integer i;
  pm_framer_model i_pm_framer_model (.clk_i(clk), .frame_o(frame), .b1_o(b1), .b2_o(b2));
  pm_section_line #(.SEC_CYCLES(50)) i_pm_section_line (
    .CLK_I(clk), .SRST_I(srst), .PERIOD_CLR_I(pclr), .FRAME_I(frame), .B1_ERR_I(b1), .B2_ERR_I(b2),
    .SEF_I(sef), .LOS_I(los), .AIS_L_I(ais), .AIS_L_FAIL_I(aisf), .LOWER_FAIL_I(lowf),
    .SEC_SES_THRESH_I(sk), .LINE_SES_THRESH_I(lk), .BLSR_MODE_I(blsr), .PATH_PROTECT_I(prot),
    .PJ_POS_DET_I(pd), .PJ_NEG_DET_I(nd), .PJ_POS_GEN_I(pg), .PJ_NEG_GEN_I(ng),
    .SECOND_TICK_O(tick), .CUR_SEC_B1_O(acc1), .CUR_SEC_B2_O(acc2),
    .SECTION_CODE_VIOLATION_COUNT_O(cvs), .SECTION_ERRORED_SECONDS_O(ess),
    .SECTION_SEVERE_ERRORED_SECONDS_O(sess), .SECTION_FRAMING_ERROR_SECONDS_O(sefs),
    .LINE_CODE_VIOLATION_COUNT_O(cvl), .LINE_ERRORED_SECONDS_O(esl),
    .LINE_SEVERE_ERRORED_SECONDS_O(sesl), .LINE_UNAVAILABLE_SECONDS_O(uas),
    .LINE_FAILURE_EVENT_COUNT_O(fc), .LINE_UNAVAILABLE_O(unav), .LINE_FAILURE_ACTIVE_O(fact),
    .PATH_POS_JUSTIFY_DETECTED_O(ppd), .PATH_NEG_JUSTIFY_DETECTED_O(pnd),
    .PATH_POS_JUSTIFY_GENERATED_O(ppg), .PATH_NEG_JUSTIFY_GENERATED_O(png));
  ////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare one value, count and report
  task chk(input [`CNT_W-1:0] got, input [`CNT_W-1:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Wait for the tick, return at the edge that closes the second
  task sec_wait;
    integer n;
    begin
      n = 0;
      @(negedge clk);
      while (tick !== 1'b1 && n < 60) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(tick, 1'b1);
      @(posedge clk);
    end
  endtask
  // Report and end the run
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    #40000;
    bad_count = bad_count + 1;
    stop_test;
  end
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {srst, pclr, sef, los, ais, aisf, lowf, blsr} = 8'h80;
    {prot, pd, nd, pg, ng} = 60'h0;
    sk = 24'h00000D;
    lk = 24'h000607;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(cvs, 32'h0);
    chk(uas, 32'h0);
    // Clipped frame counts, thresholds at their boundary
    sec_wait;
    i_pm_framer_model.send(4'h3, 11'h005, 1'b0);
    i_pm_framer_model.send(4'h9, 11'h7FF, 1'b0);
    i_pm_framer_model.send(4'h2, 11'h001, 1'b1);
    @(negedge clk);
    chk(acc1, 32'hD);
    chk(acc2, 32'h606);
    sec_wait;
    @(negedge clk);
    chk(cvs, 32'hD);
    chk(ess, 32'h1);
    chk(sess, 32'h1);
    chk(sefs, 32'h0);
    chk(cvl, 32'h606);
    chk(esl, 32'h1);
    chk(sesl, 32'h0);
    chk(acc1, 32'h0);
    $display("test frames done");
    // One cycle of severe framing defect
    @(posedge clk);
    sef <= 1'b1;
    @(posedge clk);
    sef <= 1'b0;
    sec_wait;
    @(negedge clk);
    chk(ess, 32'h2);
    chk(sess, 32'h2);
    chk(sefs, 32'h1);
    $display("test framing done");
    // Ten alarm seconds, then ten clean ones; defects held over the first tick
    @(posedge clk);
    {sef, los, ais} <= 3'h7;
    for (i = 0; i < 10; i = i + 1) begin
      sec_wait;
      {sef, los} <= 2'h0;
      ais <= (i < 9);
      @(negedge clk);
      chk(unav, i == 9);
    end
    chk(uas, 32'h1);
    chk(sesl, 32'hA);
    chk(esl, 32'hB);
    chk(ess, 32'h3);
    chk(sess, 32'h3);
    chk(sefs, 32'h2);
    for (i = 0; i < 10; i = i + 1) begin
      sec_wait;
      @(negedge clk);
      chk(unav, i < 9);
      chk(uas, (i < 9) ? i + 2 : 10);
    end
    $display("test unavailable done");
    // Justifications on four paths and a protect path
    @(posedge clk);
    blsr <= 1'b1;
    prot <= 12'h010;
    {pd, nd, pg, ng} <= {12'h011, 12'h012, 12'h014, 12'h018};
    @(posedge clk);
    {pd, nd, pg, ng} <= 48'h0;
    blsr <= 1'b0;
    @(negedge clk);
    chk(ppd[31:0], 32'h1);
    chk(pnd[63:32], 32'h1);
    chk(ppg[95:64], 32'h1);
    chk(png[127:96], 32'h1);
    chk(ppd[159:128] | png[159:128], 32'h0);
    @(posedge clk);
    pd <= 12'h010;
    @(posedge clk);
    pd <= 12'h000;
    @(negedge clk);
    chk(ppd[159:128], 32'h1);
    $display("test paths done");
    // Failure held across a period clear
    @(posedge clk);
    aisf <= 1'b1;
    repeat (2) @(negedge clk);
    chk(fc, 32'h1);
    @(posedge clk);
    pclr <= 1'b1;
    @(posedge clk);
    pclr <= 1'b0;
    repeat (3) @(negedge clk);
    chk(fc, 32'h0);
    chk(fact, 1'b1);
    chk(cvs, 32'h0);
    // Cleared failure, then a lower-layer failure is a new event
    @(posedge clk);
    aisf <= 1'b0;
    @(posedge clk);
    lowf <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(fc, 32'h1);
    chk(fact, 1'b1);
    $display("test failure done");
    stop_test;
  end
endmodule
`default_nettype wire
